// [uirq_pkg.sv]
// Package with register map, field positions and carrier types of the UART interrupt and DMA control block.
`default_nettype none

package uirq_pkg;

   // Number of interrupt sources and width of the status registers.
   localparam int unsigned SRC_N   = 11;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned DMA_W   = 3;
   localparam int unsigned EVT_W   = 2;

   // Register byte offsets on the APB.
   localparam logic [7:0] OFS_RAW    = 8'h00;
   localparam logic [7:0] OFS_MASKED = 8'h04;
   localparam logic [7:0] OFS_CLEAR  = 8'h08;
   localparam logic [7:0] OFS_DMA    = 8'h0C;
   localparam logic [7:0] OFS_MASK   = 8'h10;
   localparam logic [7:0] OFS_EVT    = 8'h14;
   localparam logic [7:0] OFS_EVTMSK = 8'h18;

   // Source positions shared by raw, masked, mask and clear registers.
   localparam int unsigned BIT_OVERRUN = 10;
   localparam int unsigned BIT_BREAK   = 9;
   localparam int unsigned BIT_PARITY  = 8;
   localparam int unsigned BIT_FRAMING = 7;
   localparam int unsigned BIT_TIMEOUT = 6;
   localparam int unsigned BIT_TX      = 5;
   localparam int unsigned BIT_RX      = 4;
   localparam int unsigned BIT_MODEM_HI = 3;

   // Error sources occupy the contiguous span framing up to overrun.
   localparam int unsigned ERR_LO = BIT_FRAMING;
   localparam int unsigned ERR_HI = BIT_OVERRUN;

   // DMA control field positions.
   localparam int unsigned DMA_RX_EN    = 0;
   localparam int unsigned DMA_TX_EN    = 1;
   localparam int unsigned DMA_STOP_ERR = 2;

   // Block event status positions.
   localparam int unsigned EVT_RX_BLOCK = 0;
   localparam int unsigned EVT_BAD_ACC  = 1;

   // Reset values.
   localparam logic [SRC_N-1:0] RAW_RST  = 11'h000;
   localparam logic [SRC_N-1:0] MASK_RST = 11'h000;
   localparam logic [DMA_W-1:0] DMA_RST  = 3'h0;
   localparam logic [EVT_W-1:0] EVT_RST  = 2'h0;
   localparam logic [DATA_W-1:0] ZERO_W  = 32'h0000_0000;

   // One bit per interrupt source, laid out in register order.
   typedef struct packed {
      logic overrun;
      logic brk;
      logic parity;
      logic framing;
      logic rx_timeout;
      logic tx;
      logic rx;
      logic set_ready;
      logic carrier;
      logic clear_to_send;
      logic ring;
   } uirq_src_s;

   // DMA request group, both as FIFO-side inputs and controller-side outputs.
   typedef struct packed {
      logic tx_single;
      logic tx_burst;
      logic rx_single;
      logic rx_burst;
   } uirq_dma_s;

endpackage : uirq_pkg

`default_nettype wire

// [uirq_flag_bank.sv]
// Bank of sticky flags where a set pulse wins over a same-cycle clear.
`default_nettype none
`timescale 1ns/1ps

module uirq_flag_bank #(
   parameter int unsigned W = 11                 // Number of flags.
) (
   input  wire logic         pclk,               // Clock.
   input  wire logic         presetn,            // Asynchronous reset, active low.
   input  wire logic         ce,                 // Clock enable, freezes flags while low.
   input  wire logic [W-1:0] set,                // Per-flag set pulses.
   input  wire logic [W-1:0] clr,                // Per-flag clear pulses.
   output logic      [W-1:0] flags               // Current flag values.
);

   // One sticky flag per bit; the set term is ORed last so it wins.
   for (genvar i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            flags[i] <= 1'b0;
         end else if (ce) begin
            flags[i] <= set[i] | (flags[i] & ~clr[i]);
         end
      end
   end

endmodule : uirq_flag_bank

`default_nettype wire

// [uirq_ctrl.sv]
// Top of the UART interrupt status and DMA request control block with its APB slave.
`default_nettype none
`timescale 1ns/1ps

module uirq_ctrl #(
   parameter int unsigned ADDR_W = 8             // APB address width.
) (
   input  wire logic                  pclk,      // Clock, 100 MHz.
   input  wire logic                  presetn,   // Asynchronous reset, active low.
   input  wire logic                  ce,        // Clock enable, freezes all state.
   input  wire logic                  psel,      // APB select.
   input  wire logic                  penable,   // APB enable.
   input  wire logic                  pwrite,    // APB direction, high for write.
   input  wire logic [ADDR_W-1:0]     paddr,     // APB byte address.
   input  wire logic [31:0]           pwdata,    // APB write data.
   output logic                       pready,    // APB ready.
   output logic      [31:0]           prdata,    // APB read data.
   output logic                       pslverr,   // APB error for unmapped addresses.
   input  wire uirq_pkg::uirq_src_s   src_evt,   // Event pulses from the UART sources.
   input  wire uirq_pkg::uirq_dma_s   dma_in,    // Raw DMA requests from the FIFO logic.
   output uirq_pkg::uirq_dma_s        dma_req,   // Gated DMA requests to the controller.
   output uirq_pkg::uirq_src_s        masked_irq,// Per-source masked interrupt lines.
   output logic                       err_irq,   // Combined error interrupt.
   output logic                       irq        // Combined interrupt line.
);

   localparam int unsigned N  = uirq_pkg::SRC_N;
   localparam int unsigned EW = uirq_pkg::EVT_W;

   // Raw status flags, one per source.
   logic [N-1:0]                  raw;
   // Mask register, one enable per source.
   logic [N-1:0]                  mask;
   // DMA control register.
   logic [uirq_pkg::DMA_W-1:0]    dma_ctrl;
   // Sticky block events and their mask.
   logic [EW-1:0]                 evt;
   logic [EW-1:0]                 evt_mask;
   // Masked view of the sources.
   logic [N-1:0]                  masked;
   // Error interrupt formed from the masked error sources.
   logic                          err_now;
   // Bus phase decode.
   logic                          setup;
   logic                          done;
   logic                          wr_done;
   logic                          rd_done;
   // Address decode.
   logic                          sel_raw;
   logic                          sel_masked;
   logic                          sel_clear;
   logic                          sel_dma;
   logic                          sel_mask;
   logic                          sel_evt;
   logic                          sel_evtmsk;
   logic                          hit;
   // Read multiplexer output.
   logic [31:0]                   rd_mux;
   // Clear and set vectors for the flag banks.
   logic [N-1:0]                  raw_clr;
   logic [N-1:0]                  raw_set;
   logic [EW-1:0]                 evt_set;
   logic [EW-1:0]                 evt_clr;
   // Receive DMA blocked by the stop-on-error option.
   logic                          rx_block;

   // Bus phases: setup is the first cycle, done the completing access edge.
   assign setup   = psel & ~penable;
   assign done    = psel & penable & pready;
   assign wr_done = done & pwrite;
   assign rd_done = done & ~pwrite;

   // Address decode against the register map.
   always_comb begin
      sel_raw    = (paddr == ADDR_W'(uirq_pkg::OFS_RAW));
      sel_masked = (paddr == ADDR_W'(uirq_pkg::OFS_MASKED));
      sel_clear  = (paddr == ADDR_W'(uirq_pkg::OFS_CLEAR));
      sel_dma    = (paddr == ADDR_W'(uirq_pkg::OFS_DMA));
      sel_mask   = (paddr == ADDR_W'(uirq_pkg::OFS_MASK));
      sel_evt    = (paddr == ADDR_W'(uirq_pkg::OFS_EVT));
      sel_evtmsk = (paddr == ADDR_W'(uirq_pkg::OFS_EVTMSK));
      hit        = sel_raw | sel_masked | sel_clear | sel_dma | sel_mask | sel_evt | sel_evtmsk;
   end

   // Masked view; a masked flag only rises while its mask bit is one.
   assign masked  = raw & mask;
   assign err_now = |masked[uirq_pkg::ERR_HI:uirq_pkg::ERR_LO];

   // Read multiplexer; unused upper bits are always zero.
   always_comb begin
      rd_mux = uirq_pkg::ZERO_W;
      if (sel_raw) begin
         rd_mux[N-1:0] = raw;
      end else if (sel_masked) begin
         rd_mux[N-1:0] = masked;
      end else if (sel_dma) begin
         rd_mux[uirq_pkg::DMA_W-1:0] = dma_ctrl;
      end else if (sel_mask) begin
         rd_mux[N-1:0] = mask;
      end else if (sel_evt) begin
         rd_mux[EW-1:0] = evt;
      end else if (sel_evtmsk) begin
         rd_mux[EW-1:0] = evt_mask;
      end
   end

   // Clear vector from a write to the clear register; zeros leave flags alone.
   assign raw_clr = (wr_done && sel_clear) ? pwdata[N-1:0] : '0;
   assign raw_set = src_evt;

   // Block events: blocked receive DMA, and access to an unmapped address.
   assign rx_block = dma_ctrl[uirq_pkg::DMA_STOP_ERR] & err_now;
   always_comb begin
      evt_set = '0;
      evt_set[uirq_pkg::EVT_RX_BLOCK] = rx_block & dma_ctrl[uirq_pkg::DMA_RX_EN]
                                        & (dma_in.rx_single | dma_in.rx_burst);
      evt_set[uirq_pkg::EVT_BAD_ACC]  = setup & ~hit;
   end
   // A completed read clears only the events it reported; one that lands after setup stays pending.
   assign evt_clr = (rd_done && sel_evt) ? prdata[EW-1:0] : '0;

   // Raw source flags; all reset to zero, the modem bits included.
   uirq_flag_bank #(
      .W       (N)
   ) u_raw (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set     (raw_set),
      .clr     (raw_clr),
      .flags   (raw)
   );

   // Sticky block events, cleared by reading them.
   uirq_flag_bank #(
      .W       (EW)
   ) u_evt (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set     (evt_set),
      .clr     (evt_clr),
      .flags   (evt)
   );

   // Ready rises for the access cycle that follows each setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (ce) begin
         pready <= setup;
      end
   end

   // Read data captured in setup so the answer comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= uirq_pkg::ZERO_W;
      end else if (ce && setup) begin
         prdata <= pwrite ? uirq_pkg::ZERO_W : rd_mux;
      end
   end

   // Error response for unmapped addresses.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (ce) begin
         pslverr <= setup & ~hit;
      end
   end

   // Mask register: ones set, zeros clear each source's mask.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= uirq_pkg::MASK_RST;
      end else if (ce && wr_done && sel_mask) begin
         mask <= pwdata[N-1:0];
      end
   end

   // DMA control register, cleared on reset so DMA starts off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_ctrl <= uirq_pkg::DMA_RST;
      end else if (ce && wr_done && sel_dma) begin
         dma_ctrl <= pwdata[uirq_pkg::DMA_W-1:0];
      end
   end

   // Event mask register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_mask <= uirq_pkg::EVT_RST;
      end else if (ce && wr_done && sel_evtmsk) begin
         evt_mask <= pwdata[EW-1:0];
      end
   end

   // Gated DMA requests; receive requests drop while blocked by an error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_req <= '0;
      end else if (ce) begin
         dma_req.tx_single <= dma_in.tx_single & dma_ctrl[uirq_pkg::DMA_TX_EN];
         dma_req.tx_burst  <= dma_in.tx_burst  & dma_ctrl[uirq_pkg::DMA_TX_EN];
         dma_req.rx_single <= dma_in.rx_single & dma_ctrl[uirq_pkg::DMA_RX_EN] & ~rx_block;
         dma_req.rx_burst  <= dma_in.rx_burst  & dma_ctrl[uirq_pkg::DMA_RX_EN] & ~rx_block;
      end
   end

   // Registered interrupt outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         masked_irq <= '0;
         err_irq    <= 1'b0;
         irq        <= 1'b0;
      end else if (ce) begin
         masked_irq <= masked;
         err_irq    <= err_now;
         irq        <= (|masked) | (|(evt & evt_mask));
      end
   end

   // A read of the raw register in setup returns the raw flags.
   sequence s_rd_setup_raw;
      ce && setup && !pwrite && sel_raw;
   endsequence
   property p_raw_read;
      @(posedge pclk) disable iff (!presetn)
      s_rd_setup_raw |=> prdata == {21'h0, $past(raw)};
   endproperty
   a_raw_read: assert property (p_raw_read) else $error("raw read data wrong");

   // Reading the masked register returns raw AND mask.
   property p_masked_read;
      @(posedge pclk) disable iff (!presetn)
      (ce && setup && !pwrite && sel_masked) |=> prdata[N-1:0] == ($past(raw) & $past(mask));
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("masked read data wrong");

   // Upper bits of every answer are zero.
   property p_upper_zero;
      @(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:N] == 21'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

   // A raw flag rises on its event even when masked off.
   property p_raw_set;
      @(posedge pclk) disable iff (!presetn)
      (ce && src_evt.overrun && !mask[uirq_pkg::BIT_OVERRUN]) |=> raw[uirq_pkg::BIT_OVERRUN];
   endproperty
   a_raw_set: assert property (p_raw_set) else $error("raw flag not set while masked");

   // A clear write without a new event drops the receive flag.
   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      (ce && wr_done && sel_clear && pwdata[uirq_pkg::BIT_RX] && !src_evt.rx) |=> !raw[uirq_pkg::BIT_RX];
   endproperty
   a_clear: assert property (p_clear) else $error("clear write did not clear");

   // A same-cycle event wins over a clear of the transmit flag.
   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      (ce && wr_done && sel_clear && pwdata[uirq_pkg::BIT_TX] && src_evt.tx) |=> raw[uirq_pkg::BIT_TX];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

   // Stop-on-error silences receive DMA while the error interrupt holds.
   property p_rx_stop;
      @(posedge pclk) disable iff (!presetn)
      (ce && dma_ctrl[uirq_pkg::DMA_STOP_ERR] && err_now) |=> !dma_req.rx_single && !dma_req.rx_burst;
   endproperty
   a_rx_stop: assert property (p_rx_stop) else $error("rx dma not blocked on error");

   // Transmit DMA requests only with transmit enable.
   property p_tx_gate;
      @(posedge pclk) disable iff (!presetn)
      (ce && !dma_ctrl[uirq_pkg::DMA_TX_EN]) |=> !dma_req.tx_single && !dma_req.tx_burst;
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("tx dma request while disabled");

   // The receive single DMA request follows the enabled source one cycle later.
   property p_rx_gate;
      @(posedge pclk) disable iff (!presetn)
      (ce && dma_in.rx_single) |=> dma_req.rx_single == ($past(dma_ctrl[uirq_pkg::DMA_RX_EN]) && !$past(rx_block));
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("rx dma single request wrong");

   // The combined interrupt tracks the masked flags.
   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (ce && |masked) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing for masked flag");

   // Ready answers every setup cycle one edge later.
   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      (ce && setup) |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready missing after setup");

   // An unmapped address is answered with an error in the access cycle.
   property p_slverr;
      @(posedge pclk) disable iff (!presetn)
      (ce && setup && !hit) |=> pready && pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("no error for unmapped address");

   // The error interrupt follows the masked error flags one edge later.
   property p_err_irq;
      @(posedge pclk) disable iff (!presetn)
      ce |=> err_irq == $past(err_now);
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error interrupt wrong");

   // The combined interrupt drops once nothing unmasked is pending.
   property p_irq_low;
      @(posedge pclk) disable iff (!presetn)
      (ce && !(|masked) && !(|(evt & evt_mask))) |=> !irq;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq without masked flag");

   // A completed write to the register picked by sel.
   sequence s_reg_write(sel);
      ce && wr_done && sel;
   endsequence

   // A mask write takes the written bits as they stand.
   property p_mask_write;
      @(posedge pclk) disable iff (!presetn)
      s_reg_write(sel_mask) |=> mask == $past(pwdata[N-1:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write not taken");

   // A DMA control write takes the written bits as they stand.
   property p_dma_write;
      @(posedge pclk) disable iff (!presetn)
      s_reg_write(sel_dma) |=> dma_ctrl == $past(pwdata[uirq_pkg::DMA_W-1:0]);
   endproperty
   a_dma_write: assert property (p_dma_write) else $error("dma control write not taken");

   // Right after reset release non-modem flags and DMA control are zero.
   property p_reset_vals;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> raw[N-1:uirq_pkg::BIT_RX] == 7'h00 && dma_ctrl == uirq_pkg::DMA_RST;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

endmodule : uirq_ctrl

`default_nettype wire

// [uirq_dma_host.sv]
// Model of the DMA controller that watches the gated request lines.
`timescale 1ns/1ps
`default_nettype none

module uirq_dma_host (
   input  wire logic                pclk,     // Clock.
   input  wire logic                presetn,  // Asynchronous reset, active low.
   input  wire uirq_pkg::uirq_dma_s dma_req,  // Requests from the block.
   output var  uirq_pkg::uirq_dma_s seen      // Requests as latched by the controller.
);

   // Latch the request lines on every edge, as the controller's arbiter does.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen <= '0;
      end else begin
         seen <= dma_req;
      end
   end

endmodule : uirq_dma_host

`default_nettype wire

// [test_uart_irq_status_dma_ctrl.sv]
// Self-checking testbench of the interrupt status and DMA control block.
`timescale 1ns/1ps
`default_nettype none

module test_uart_irq_status_dma_ctrl;

   logic                pclk, presetn, ce, psel, penable, pwrite;  // Clock, reset and bus controls.
   logic                pready, pslverr, err_irq, irq, er;         // Design outputs and captured error.
   logic [7:0]          paddr;                                     // Bus address.
   logic [31:0]         pwdata, prdata, rd;                        // Bus data and captured read data.
   uirq_pkg::uirq_src_s src_evt, masked_irq;                       // Event pulses and masked lines.
   uirq_pkg::uirq_dma_s dma_in, dma_req, seen;                     // Request groups.
   logic [10:0]         raw, mask, ev, cl;                         // Expected flags and stimulus.
   logic [3:0]          din, e4;                                   // Request levels and expectation.
   int                  n_fail, n_tests;                           // Mismatch and compare counters.

   uirq_ctrl #(.ADDR_W(8)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .src_evt(src_evt), .dma_in(dma_in), .dma_req(dma_req),
      .masked_irq(masked_irq), .err_irq(err_irq), .irq(irq));

   uirq_dma_host host_u (.pclk(pclk), .presetn(presetn), .dma_req(dma_req), .seen(seen));

   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Prints the verdict and ends the run.
   task automatic conclude();
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask : chk

   // One bus transfer; e pulses events so they land on the access edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [10:0] e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      src_evt <= uirq_pkg::uirq_src_s'(e);
      k = 0;
      // Ready is looked at on rising edges only; the request stands until it is seen high, for at most 17 edges.
      @(posedge pclk);
      while (pready !== 1'b1 && k < 16) begin
         @(posedge pclk);
         k++;
      end
      if (pready !== 1'b1) begin
         n_fail++;
         conclude();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         src_evt <= '0;
      end
   endtask : apb

   // Reads a register and compares the whole word.
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, 11'h000);
      chk(rd, exp);
   endtask : rdchk

   // Pulses the event inputs for one cycle.
   task automatic evt(input logic [10:0] e);
      @(posedge pclk);
      src_evt <= uirq_pkg::uirq_src_s'(e);
      @(posedge pclk);
      src_evt <= '0;
   endtask : evt

   // Expected gated requests: tx by its enable, rx by its enable unless stopped on error.
   function automatic logic [3:0] exp_dma(input logic [2:0] c, input logic e, input logic [3:0] d);
      logic rx_ok;
      rx_ok = c[0] & ~(c[2] & e);
      return d & {c[1], c[1], rx_ok, rx_ok};
   endfunction : exp_dma

   // Main sequence.
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      src_evt = '0;
      dma_in = '0;
      {n_fail, n_tests} = '0;
      raw = '0;
      void'($urandom(32'hd9c6_8cf8));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, uirq_pkg::OFS_RAW, 32'h0000_0000, 11'h000);
      chk(rd & 32'hFFFF_FFF0, 32'h0000_0000);
      apb(1'b0, uirq_pkg::OFS_MASKED, 32'h0000_0000, 11'h000);
      chk(rd & 32'hFFFF_FFF0, 32'h0000_0000);
      rdchk(uirq_pkg::OFS_DMA, 32'h0000_0000);
      // With the clock enable low an event must not be recorded.
      ce <= 1'b0;
      evt(11'h7F0);
      ce <= 1'b1;
      apb(1'b0, uirq_pkg::OFS_RAW, 32'h0000_0000, 11'h000);
      chk(rd & 32'hFFFF_FFF0, 32'h0000_0000);
      // Unmapped address answers with an error and logs an event that raises irq once unmasked.
      apb(1'b1, uirq_pkg::OFS_EVTMSK, 32'h0000_0002, 11'h000);
      rdchk(uirq_pkg::OFS_EVTMSK, 32'h0000_0002);
      apb(1'b0, 8'h1C, 32'h0000_0000, 11'h000);
      chk({31'h0, er}, 32'h0000_0001);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0001);
      rdchk(uirq_pkg::OFS_EVT, 32'h0000_0002);
      rdchk(uirq_pkg::OFS_EVT, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      rdchk(uirq_pkg::OFS_CLEAR, 32'h0000_0000);
      raw = '0;
      apb(1'b1, uirq_pkg::OFS_CLEAR, 32'h0000_07FF, 11'h000);
      // Random events, masks and clears, with a new event colliding with each clear.
      for (int i = 0; i < 40; i++) begin
         mask = 11'($urandom);
         ev = 11'($urandom);
         cl = 11'($urandom);
         apb(1'b1, uirq_pkg::OFS_MASK, {21'h0, mask}, 11'h000);
         evt(ev);
         raw = raw | ev;
         ev = 11'($urandom);
         apb(1'b1, uirq_pkg::OFS_CLEAR, {21'h0, cl}, ev);
         raw = (raw & ~cl) | ev;
         apb(1'b1, i[0] ? uirq_pkg::OFS_RAW : uirq_pkg::OFS_MASKED, {21'h0, 11'($urandom)}, 11'h000);
         rdchk(uirq_pkg::OFS_RAW, {21'h0, raw});
         rdchk(uirq_pkg::OFS_MASKED, {21'h0, raw & mask});
         rdchk(uirq_pkg::OFS_MASK, {21'h0, mask});
         chk({21'h0, masked_irq}, {21'h0, raw & mask});
         chk({31'h0, irq}, {31'h0, |(raw & mask)});
         chk({31'h0, err_irq}, {31'h0, |(raw[10:7] & mask[10:7])});
      end
      // Every DMA control setting, with and without a pending error.
      apb(1'b1, uirq_pkg::OFS_MASK, 32'h0000_0400, 11'h000);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, uirq_pkg::OFS_DMA, {29'h0, 3'(i)}, 11'h000);
         rdchk(uirq_pkg::OFS_DMA, {29'h0, 3'(i)});
         if (i[3]) begin
            evt(11'h400);
         end else begin
            apb(1'b1, uirq_pkg::OFS_CLEAR, 32'h0000_0400, 11'h000);
         end
         din = 4'($urandom);
         dma_in <= din;
         repeat (4) @(posedge pclk);
         e4 = exp_dma(3'(i), i[3], din);
         chk({24'h0, dma_req, seen}, {24'h0, e4, e4});
      end
      // A reset in mid-run returns DMA control, the requests and the non-modem flags to zero.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(uirq_pkg::OFS_DMA, 32'h0000_0000);
      apb(1'b0, uirq_pkg::OFS_RAW, 32'h0000_0000, 11'h000);
      chk(rd & 32'hFFFF_FFF0, 32'h0000_0000);
      chk({24'h0, dma_req, seen}, 32'h0000_0000);
      conclude();
   end

endmodule : test_uart_irq_status_dma_ctrl

`default_nettype wire
